// ===== rtl/ica_pkg.sv
`default_nettype none
package ica_pkg;
  // ==========================================================
  // metadata items, in selector order
  localparam int         ICA_ITEMS    = 15;
  localparam logic [3:0] ITEM_IMAGE   = 4'h0;
  localparam logic [3:0] ITEM_CHECK   = 4'h1;
  localparam logic [3:0] ITEM_FRAME   = 4'h2;
  localparam logic [3:0] ITEM_ROIX    = 4'h3;
  localparam logic [3:0] ITEM_ROIY    = 4'h4;
  localparam logic [3:0] ITEM_WIDTH   = 4'h5;
  localparam logic [3:0] ITEM_HEIGHT  = 4'h6;
  localparam logic [3:0] ITEM_EXPOSE  = 4'h7;
  localparam logic [3:0] ITEM_GAIN    = 4'h8;
  localparam logic [3:0] ITEM_BLACK   = 4'h9;
  localparam logic [3:0] ITEM_FORMAT  = 4'ha;
  localparam logic [3:0] ITEM_STAMP   = 4'hb;
  localparam logic [3:0] ITEM_SEQ     = 4'hc;
  localparam logic [3:0] ITEM_SERIAL  = 4'hd;
  localparam logic [3:0] ITEM_LINES   = 4'he;
  localparam logic [14:0] ENABLE_RESET  = 15'h0003;
  localparam logic [14:0] ENABLE_LOCKED = 15'h0003;
  // value bytes per item
  localparam logic [3:0] LEN_W32   = 4'h4;
  localparam logic [3:0] LEN_W16   = 4'h2;
  localparam logic [3:0] LEN_W8    = 4'h1;
  localparam logic [3:0] LEN_W64   = 4'h8;
  localparam logic [3:0] LEN_SERHD = 4'h2;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_PICK    = 8'h04;
  localparam logic [7:0] REG_INCLUDE = 8'h08;
  localparam logic [7:0] REG_ENABLES = 8'h0c;
  localparam logic [7:0] REG_GAINPK  = 8'h10;
  localparam logic [7:0] REG_BLACKPK = 8'h14;
  localparam logic [7:0] REG_STATUS  = 8'h18;
  localparam logic [7:0] REG_LASTCHK = 8'h1c;
  localparam logic [7:0] REG_SERCNT  = 8'h20;
  localparam int STAT_RUN     = 0;
  localparam int STAT_REJECT  = 1;
  localparam int STAT_OVERRUN = 2;
  localparam int STAT_BUSY    = 3;
  // ==========================================================
  // check value and format codes
  localparam logic [31:0] CRC_POLY = 32'hedb88320;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] CRC_XOR  = 32'hffffffff;
  localparam int          FMT_NUM  = 10;
  // mono8, mono12p, mono16, rgb8, yuv422, four bayer8, ycbcr422
  localparam logic [7:0] FMT_CODE [0:9] = '{8'h01, 8'h02, 8'h03,
    8'h10, 8'h20, 8'h30, 8'h31, 8'h32, 8'h33, 8'h21};
  typedef enum logic [2:0] {S_IMAGE, S_TAG, S_LEN, S_VAL, S_SER} ica_state_t;
endpackage
`default_nettype wire

// ===== rtl/ica_chunk_appender.sv
`timescale 1ns/1ns
`default_nettype none
// Operation
// - switch set appends enabled metadata chunks; switch clear appends none
// - image and check-value enables reset set and cannot be cleared
// - include write applies only to the item currently picked
// - configuration writes are refused while acquisition runs
// - picker offers fifteen items from image to line snapshot
// - check-value chunk carries check over the accompanying image
// - frame number chunk carries the frame's identifier
// - width and height chunks report the carried image size
// - offset chunks report the carried image's region origin
// - exposure chunk reports the exposure used for that image
// - gain chunk reports gain picked by a separate gain selector
// - black level chunk reports the single black level; its selector has no effect
// - timestamp chunk carries the image capture time
// - sequencer chunk reports the active sequence index
// - line chunk reports line levels snapped at exposure end
// - serial chunk carries received bytes plus their count
// - serial chunk holds a read-only receive overrun flag
// - format chunk carries one of the defined format codes
module ica_chunk_appender import ica_pkg::*; #(
  parameter int unsigned SER_DEPTH = 16,
  parameter int unsigned NUM_LINES = 4
) (
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic [7:0]           regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic      [31:0]          regRdData,
  input  wire logic                 acqRunning,
  input  wire logic                 frameStart,
  input  wire logic [31:0]          frameNumber,
  input  wire logic [15:0]          roiX,
  input  wire logic [15:0]          roiY,
  input  wire logic [15:0]          imgWidth,
  input  wire logic [15:0]          imgHeight,
  input  wire logic [31:0]          exposureUs,
  input  wire logic [63:0]          gainLevels,
  input  wire logic [15:0]          blackLevel,
  input  wire logic [3:0]           fmtIndex,
  input  wire logic [63:0]          captureTime,
  input  wire logic [7:0]           seqIndex,
  input  wire logic                 exposureEnd,
  input  wire logic [NUM_LINES-1:0] lineLevels,
  input  wire logic                 serRxValid,
  input  wire logic [7:0]           serRxData,
  input  wire logic [7:0]           imgData,
  input  wire logic                 imgValid,
  input  wire logic                 imgLast,
  output logic                      imgReady,
  output logic      [7:0]           outData,
  output logic                      outValid,
  output logic                      outLast,
  input  wire logic                 outReady,
  output logic                      frameDone
);
  localparam int PW = $clog2(SER_DEPTH);
  localparam int CW = $clog2(SER_DEPTH + 1);

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  // ==========================================================
  // configuration registers
  logic             modeSwitch;
  logic [3:0]       pick;
  logic [1:0]       gainPick;
  logic             blackPick;
  logic [14:0]      enables;
  logic             rejectFlag;
  logic [14:0]      pickMask;
  logic             cfgWrite;
  logic [31:0]      lastCrc;
  logic [CW-1:0]    serSnap;
  logic             serOverrun;
  logic [CW-1:0]    serCnt;
  ica_state_t       state;

  assign pickMask = 15'h0001 << pick;
  assign cfgWrite = regWr && (regAddr == REG_CTRL || regAddr == REG_INCLUDE);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      modeSwitch <= 1'b0;
      pick       <= ITEM_IMAGE;
      gainPick   <= 2'h0;
      blackPick  <= 1'b0;
      enables    <= ENABLE_RESET;
    end else if (regWr && !acqRunning) begin
      case (regAddr)
        REG_CTRL:    modeSwitch <= regWrData[0];
        REG_PICK:    pick <= regWrData[3:0];
        REG_INCLUDE: begin
          if (pick < 4'(ICA_ITEMS)) begin
            // locked items keep their enable whatever is written
            enables[pick] <= regWrData[0] | ENABLE_LOCKED[pick];
          end
        end
        REG_GAINPK:  gainPick <= regWrData[1:0];
        REG_BLACKPK: blackPick <= regWrData[0];
        default: ;
      endcase
    end
  end

  // refusal is sticky; a new refusal beats a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rejectFlag <= 1'b0;
    end else begin
      if (regWr && regAddr == REG_STATUS && regWrData[STAT_REJECT]) begin
        rejectFlag <= 1'b0;
      end
      if (cfgWrite && acqRunning) begin
        rejectFlag <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      regRdData <= 32'h0;
    end else if (regRd) begin
      case (regAddr)
        REG_CTRL:    regRdData <= {31'h0, modeSwitch};
        REG_PICK:    regRdData <= {28'h0, pick};
        REG_INCLUDE: regRdData <= {31'h0, |(enables & pickMask)};
        REG_ENABLES: regRdData <= {17'h0, enables};
        REG_GAINPK:  regRdData <= {30'h0, gainPick};
        REG_BLACKPK: regRdData <= {31'h0, blackPick};
        REG_STATUS:  regRdData <= {28'h0, state != S_IMAGE, serOverrun,
                                   rejectFlag, acqRunning};
        REG_LASTCHK: regRdData <= lastCrc;
        REG_SERCNT:  regRdData <= 32'(serSnap);
        default:     regRdData <= 32'h0;
      endcase
    end else begin
      regRdData <= 32'h0;
    end
  end

  locked_en_a: assert property (enables[1:0] == 2'b11)
    else $error("image or check enable was cleared");
  pick_only_a: assert property (
    (regWr && regAddr == REG_INCLUDE && !acqRunning)
    |=> (((enables ^ $past(enables)) & ~$past(pickMask)) == 15'h0))
    else $error("include write touched an item not picked");
  frozen_cfg_a: assert property (
    (regWr && acqRunning) |=> $stable(enables) && $stable(modeSwitch)
      ##0 rejectFlag == $past(cfgWrite) || rejectFlag == $past(rejectFlag))
    else $error("configuration changed while running");

  // ==========================================================
  // per-frame metadata, captured at frame start; line levels at exposure end
  logic [31:0]          metaFrame;
  logic [15:0]          metaX;
  logic [15:0]          metaY;
  logic [15:0]          metaW;
  logic [15:0]          metaH;
  logic [31:0]          metaExp;
  logic [15:0]          metaGain;
  logic [15:0]          metaBlack;
  logic [7:0]           metaFmt;
  logic [63:0]          metaTime;
  logic [7:0]           metaSeq;
  logic [NUM_LINES-1:0] lineSnap;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      metaFrame <= 32'h0;
      metaX     <= 16'h0;
      metaY     <= 16'h0;
      metaW     <= 16'h0;
      metaH     <= 16'h0;
      metaExp   <= 32'h0;
      metaGain  <= 16'h0;
      metaBlack <= 16'h0;
      metaFmt   <= 8'h0;
      metaTime  <= 64'h0;
      metaSeq   <= 8'h0;
    end else if (frameStart) begin
      metaFrame <= frameNumber;
      metaX     <= roiX;
      metaY     <= roiY;
      metaW     <= imgWidth;
      metaH     <= imgHeight;
      metaExp   <= exposureUs;
      metaGain  <= gainLevels[gainPick*16 +: 16];
      // only one black level channel exists, so the pick is moot
      metaBlack <= blackLevel;
      // unknown indices fall back to the first code
      metaFmt   <= (fmtIndex < 4'(FMT_NUM)) ? FMT_CODE[fmtIndex]
                                            : FMT_CODE[0];
      metaTime  <= captureTime;
      metaSeq   <= seqIndex;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      lineSnap <= '0;
    end else if (exposureEnd) begin
      lineSnap <= lineLevels;
    end
  end

  frame_latch_a: assert property (frameStart |=>
    metaFrame == $past(frameNumber) && metaW == $past(imgWidth))
    else $error("frame metadata not captured at frame start");
  line_snap_a: assert property (exposureEnd |=>
    lineSnap == $past(lineLevels) ##1 ($past(exposureEnd) || $stable(lineSnap)))
    else $error("line snapshot wrong or drifted");

  // ==========================================================
  // serial receive ring
  logic [7:0]    serBuf [SER_DEPTH];
  logic [PW-1:0] wrPtr;
  logic [PW-1:0] rdPtr;
  logic          serPush;
  logic          serPop;
  logic          serialDone;

  assign serPush = serRxValid && serCnt != CW'(SER_DEPTH);

  always_ff @(posedge clk_sys) begin
    if (serPush) begin
      serBuf[wrPtr] <= serRxData;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPtr  <= '0;
      rdPtr  <= '0;
      serCnt <= '0;
    end else begin
      if (serPush) begin
        wrPtr <= (wrPtr == PW'(SER_DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (serPop) begin
        rdPtr <= (rdPtr == PW'(SER_DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      case ({serPush, serPop})
        2'b10:   serCnt <= serCnt + 1'b1;
        2'b01:   serCnt <= serCnt - 1'b1;
        default: ;
      endcase
    end
  end

  // overrun is cleared once reported; a new overrun wins the tie
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      serOverrun <= 1'b0;
    end else begin
      if (serialDone) begin
        serOverrun <= 1'b0;
      end
      if (serRxValid && !serPush) begin
        serOverrun <= 1'b1;
      end
    end
  end

  overrun_a: assert property (
    (serRxValid && serCnt == CW'(SER_DEPTH)) |=> serOverrun)
    else $error("full receive ring did not flag overrun");

  // ==========================================================
  // payload framer
  logic [31:0] crc;
  logic [14:0] frameEn;
  logic [3:0]  curItem;
  logic [3:0]  nextItem;
  logic        hasMore;
  logic [63:0] valReg;
  logic [3:0]  valLeft;
  logic [CW-1:0] serLeft;
  logic [63:0] itemVal;
  logic [3:0]  itemLen;
  logic        adv;
  logic        imgTake;
  logic        lastVal;
  logic        toSer;
  logic        itemDone;

  function automatic logic [31:0] crcByte(input logic [31:0] c,
                                          input logic [7:0]  d);
    logic [31:0] r;
    r = c ^ {24'h0, d};
    for (int k = 0; k < 8; k++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // next enabled item above the current one; fixed ascending order
  always_comb begin
    nextItem = ITEM_IMAGE;
    hasMore  = 1'b0;
    for (int i = ICA_ITEMS - 1; i > 0; i--) begin
      if (frameEn[i] && 4'(i) > curItem) begin
        nextItem = 4'(i);
        hasMore  = 1'b1;
      end
    end
  end

  always_comb begin
    itemVal = 64'h0;
    itemLen = LEN_W8;
    case (curItem)
      ITEM_CHECK:  begin itemVal = {32'h0, lastCrc};   itemLen = LEN_W32; end
      ITEM_FRAME:  begin itemVal = {32'h0, metaFrame}; itemLen = LEN_W32; end
      ITEM_ROIX:   begin itemVal = {48'h0, metaX};     itemLen = LEN_W16; end
      ITEM_ROIY:   begin itemVal = {48'h0, metaY};     itemLen = LEN_W16; end
      ITEM_WIDTH:  begin itemVal = {48'h0, metaW};     itemLen = LEN_W16; end
      ITEM_HEIGHT: begin itemVal = {48'h0, metaH};     itemLen = LEN_W16; end
      ITEM_EXPOSE: begin itemVal = {32'h0, metaExp};   itemLen = LEN_W32; end
      ITEM_GAIN:   begin itemVal = {48'h0, metaGain};  itemLen = LEN_W16; end
      ITEM_BLACK:  begin itemVal = {48'h0, metaBlack}; itemLen = LEN_W16; end
      ITEM_FORMAT: begin itemVal = {56'h0, metaFmt};   itemLen = LEN_W8;  end
      ITEM_STAMP:  begin itemVal = metaTime;           itemLen = LEN_W64; end
      ITEM_SEQ:    begin itemVal = {56'h0, metaSeq};   itemLen = LEN_W8;  end
      ITEM_SERIAL: begin
        itemVal = {48'h0, 8'(serSnap), 7'h0, serOverrun};
        itemLen = LEN_SERHD;
      end
      ITEM_LINES:  begin itemVal = {56'h0, 8'(lineSnap)}; itemLen = LEN_W8; end
      default: ;
    endcase
  end

  assign adv        = !outValid || outReady;
  assign imgTake    = state == S_IMAGE && imgValid && imgReady;
  assign lastVal    = state == S_VAL && adv && valLeft == 4'h1;
  assign toSer      = lastVal && curItem == ITEM_SERIAL && serSnap != '0;
  assign itemDone   = (lastVal && !toSer)
                   || (state == S_SER && adv && serLeft == CW'(1));
  assign serPop     = state == S_SER && adv;
  assign serialDone = itemDone && curItem == ITEM_SERIAL;

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state     <= S_IMAGE;
      outData   <= 8'h0;
      outValid  <= 1'b0;
      outLast   <= 1'b0;
      imgReady  <= 1'b0;
      frameDone <= 1'b0;
      crc       <= CRC_INIT;
      lastCrc   <= 32'h0;
      frameEn   <= ENABLE_RESET;
      curItem   <= ITEM_IMAGE;
      valReg    <= 64'h0;
      valLeft   <= 4'h0;
      serLeft   <= '0;
      serSnap   <= '0;
    end else begin
      frameDone <= 1'b0;
      if (outValid && outReady) begin
        outValid <= 1'b0;
      end
      case (state)
        S_IMAGE: begin
          if (imgTake) begin
            outData  <= imgData;
            outValid <= 1'b1;
            imgReady <= 1'b0;
            crc      <= crcByte(crc, imgData);
            outLast  <= imgLast && !modeSwitch;
            if (imgLast) begin
              lastCrc <= crcByte(crc, imgData) ^ CRC_XOR;
              crc     <= CRC_INIT;
              frameEn <= enables;
              serSnap <= serCnt;
              if (modeSwitch) begin
                curItem <= ITEM_CHECK;
                state   <= S_TAG;
              end else begin
                frameDone <= 1'b1;
              end
            end
          end else begin
            // one byte in flight: input is offered only to an empty slot
            imgReady <= !(outValid && !outReady);
          end
        end
        S_TAG: begin
          if (adv) begin
            outData  <= {4'h0, curItem};
            outValid <= 1'b1;
            outLast  <= 1'b0;
            valReg   <= itemVal;
            valLeft  <= itemLen;
            state    <= S_LEN;
          end
        end
        S_LEN: begin
          if (adv) begin
            outData  <= (curItem == ITEM_SERIAL)
                      ? 8'(serSnap) + 8'(LEN_SERHD)
                      : {4'h0, valLeft};
            outValid <= 1'b1;
            state    <= S_VAL;
          end
        end
        S_VAL: begin
          if (adv) begin
            outData  <= valReg[7:0];
            outValid <= 1'b1;
            valReg   <= valReg >> 8;
            valLeft  <= valLeft - 4'h1;
            if (toSer) begin
              serLeft <= serSnap;
              state   <= S_SER;
            end
          end
        end
        S_SER: begin
          if (adv) begin
            outData  <= serBuf[rdPtr];
            outValid <= 1'b1;
            serLeft  <= serLeft - CW'(1);
          end
        end
        default: state <= S_IMAGE;
      endcase
      if (itemDone) begin
        if (hasMore) begin
          curItem <= nextItem;
          state   <= S_TAG;
        end else begin
          outLast   <= 1'b1;
          frameDone <= 1'b1;
          curItem   <= ITEM_IMAGE;
          state     <= S_IMAGE;
        end
      end
    end
  end

  switch_off_a: assert property (
    (imgTake && imgLast && !modeSwitch)
    |=> outValid && outLast && frameDone && state == S_IMAGE)
    else $error("chunk appended with switch clear");
  check_first_a: assert property (
    (imgTake && imgLast && modeSwitch)
    |=> state == S_TAG && curItem == ITEM_CHECK && !outLast
      ##0 lastCrc == (crcByte($past(crc), $past(imgData)) ^ CRC_XOR))
    else $error("check chunk not first or value wrong");
  tag_order_a: assert property (
    (state == S_TAG && adv) |=> outValid && outData == {4'h0, $past(curItem)}
      ##0 state == S_LEN ##1 (state == S_LEN || state == S_VAL))
    else $error("chunk tag not emitted in order");
endmodule
`default_nettype wire

// ===== sim/ica_host_sink.sv
`timescale 1ns/1ns
`default_nettype none
// ======================================================
// host side: takes payload bytes, may stall the stream
module ica_host_sink (
  input  wire logic clk_sys,
  input  wire logic srst,
  input  wire logic stallMode,
  output logic      outReady
);
  logic [2:0] phase;
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      phase <= 3'h0;
    end else begin
      phase <= phase + 3'h1;
    end
  end
  // a slow host is ready two cycles in eight, not in step with the bytes
  assign outReady = !stallMode || (phase[1:0] == 2'h3);
endmodule
`default_nettype wire

// ===== sim/image_chunk_appender_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module image_chunk_appender_tb_top import ica_pkg::*;;
  logic        clk_sys, srst, regWr, regRd, acqRunning, frameStart;
  logic        exposureEnd, serRxValid, imgValid, imgLast, stallMode;
  logic        imgReady, outValid, outLast, outReady, frameDone;
  logic [7:0]  regAddr, seqIndex, serRxData, imgData, outData;
  logic [31:0] regWrData, regRdData, frameNumber, exposureUs;
  logic [15:0] roiX, roiY, imgWidth, imgHeight, blackLevel;
  logic [63:0] gainLevels, captureTime;
  logic [3:0]  fmtIndex, lineLevels;
  logic [7:0]  got[$];
  logic [7:0]  exp[$];
  int          n_fail, check_count, nDone, lastAt;

  ica_chunk_appender dut (.clk_sys(clk_sys), .srst(srst),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr),
    .regRd(regRd), .regRdData(regRdData), .acqRunning(acqRunning),
    .frameStart(frameStart), .frameNumber(frameNumber), .roiX(roiX),
    .roiY(roiY), .imgWidth(imgWidth), .imgHeight(imgHeight),
    .exposureUs(exposureUs), .gainLevels(gainLevels),
    .blackLevel(blackLevel), .fmtIndex(fmtIndex),
    .captureTime(captureTime), .seqIndex(seqIndex),
    .exposureEnd(exposureEnd), .lineLevels(lineLevels),
    .serRxValid(serRxValid), .serRxData(serRxData), .imgData(imgData),
    .imgValid(imgValid), .imgLast(imgLast), .imgReady(imgReady),
    .outData(outData), .outValid(outValid), .outLast(outLast),
    .outReady(outReady), .frameDone(frameDone));
  ica_host_sink host (.clk_sys(clk_sys), .srst(srst),
    .stallMode(stallMode), .outReady(outReady));

  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) begin
    if (outValid && outReady) begin
      got.push_back(outData);
      if (outLast) lastAt = got.size();
    end
    if (frameDone) nDone++;
  end

  // ======================================================
  // access and compare tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    chk(regRdData, e);
    // hand back on a rising edge so that callers drive inputs there
    @(posedge clk_sys);
  endtask
  function automatic logic [31:0] crcOf(input logic [7:0] b[$]);
    logic [31:0] c;
    c = 32'hffffffff;
    foreach (b[i]) begin
      c = c ^ {24'h0, b[i]};
      for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction
  task automatic add(input logic [7:0] t, input int n, input logic [63:0] v);
    exp.push_back(t);
    exp.push_back(8'(n));
    for (int i = 0; i < n; i++) exp.push_back(v[8*i +: 8]);
  endtask
  task automatic serSend(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_sys);
      serRxValid <= 1'b1;
      serRxData <= 8'(8'hc0 + i);
      @(posedge clk_sys);
      serRxValid <= 1'b0;
    end
  endtask

  // ======================================================
  // one frame: metadata, image bytes, expected payload
  task automatic runFrame(input int n, input logic on);
    logic [7:0] img[$];
    got.delete();
    nDone = 0;
    lastAt = 0;
    @(posedge clk_sys);
    frameStart <= 1'b1;
    exposureEnd <= 1'b1;
    lineLevels <= 4'ha;
    @(posedge clk_sys);
    frameStart <= 1'b0;
    exposureEnd <= 1'b0;
    lineLevels <= 4'h5;
    for (int i = 0; i < n; i++) begin
      img.push_back(8'(8'h5a ^ (i * 7)));
      imgValid <= 1'b1;
      imgData <= img[i];
      imgLast <= (i == n - 1);
      do @(posedge clk_sys); while (!imgReady);
    end
    imgValid <= 1'b0;
    imgLast <= 1'b0;
    exp = img;
    if (on) begin
      add(8'h01, 4, 64'(crcOf(img)));
      add(8'h02, 4, 64'(frameNumber));
      add(8'h03, 2, 64'(roiX));
      add(8'h04, 2, 64'(roiY));
      add(8'h05, 2, 64'(imgWidth));
      add(8'h06, 2, 64'(imgHeight));
      add(8'h07, 4, 64'(exposureUs));
      add(8'h08, 2, 64'(gainLevels[47:32]));
      add(8'h09, 2, 64'(blackLevel));
      add(8'h0a, 1, 64'h10);
      add(8'h0b, 8, captureTime);
      add(8'h0c, 1, 64'(seqIndex));
      add(8'h0d, 5, 64'h00_c2c1c0_03_00);
      add(8'h0e, 1, 64'ha);
    end
    repeat (3000) if (got.size() < exp.size()) @(posedge clk_sys);
    repeat (4) @(posedge clk_sys);
    chk(got.size(), exp.size());
    foreach (exp[i]) chk(got[i], exp[i]);
    chk(lastAt, exp.size());
    chk(nDone, 1);
    rdChk(REG_LASTCHK, crcOf(img));
  endtask

  task automatic give_verdict;
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    // the tests need well under a thousand cycles; allow ten thousand
    #40000;
    n_fail++;
    give_verdict();
  end

  initial begin
    {srst, regWr, regRd, acqRunning, frameStart, exposureEnd} = 6'h20;
    {serRxValid, imgValid, imgLast, stallMode} = 4'h0;
    {regAddr, seqIndex, serRxData, imgData} = {8'h0, 8'h2b, 8'h0, 8'h0};
    {regWrData, frameNumber, exposureUs} = {32'h0, 32'h1234abcd, 32'h7d0};
    {roiX, roiY, imgWidth, imgHeight} = 64'h0010_0020_0040_0030;
    blackLevel = 16'h01f4;
    gainLevels = 64'h4444_3333_2222_1111;
    captureTime = 64'h0102030405060708;
    fmtIndex = 4'h3;
    lineLevels = 4'h0;
    repeat (6) @(posedge clk_sys);
    srst <= 1'b0;
    rdChk(REG_ENABLES, 32'h3);
    rdChk(8'h40, 32'h0);
    wr(REG_PICK, 32'h0);
    wr(REG_INCLUDE, 32'h0);
    wr(REG_PICK, 32'h1);
    wr(REG_INCLUDE, 32'h0);
    rdChk(REG_ENABLES, 32'h3);
    wr(REG_PICK, 32'hf);
    wr(REG_INCLUDE, 32'h1);
    rdChk(REG_ENABLES, 32'h3);
    for (int i = 2; i < 15; i++) begin
      wr(REG_PICK, 32'(i));
      wr(REG_INCLUDE, 32'h1);
      rdChk(REG_INCLUDE, 32'h1);
      rdChk(REG_ENABLES, (32'h1 << (i + 1)) - 32'h1);
    end
    wr(REG_GAINPK, 32'h2);
    acqRunning <= 1'b1;
    stallMode <= 1'b1;
    runFrame(5, 1'b0);
    wr(REG_CTRL, 32'h1);
    wr(REG_PICK, 32'h2);
    wr(REG_INCLUDE, 32'h0);
    rdChk(REG_STATUS, 32'h3);
    rdChk(REG_CTRL, 32'h0);
    rdChk(REG_ENABLES, 32'h7fff);
    acqRunning <= 1'b0;
    wr(REG_STATUS, 32'h2);
    rdChk(REG_STATUS, 32'h0);
    wr(REG_CTRL, 32'h1);
    serSend(3);
    acqRunning <= 1'b1;
    runFrame(9, 1'b1);
    rdChk(REG_SERCNT, 32'h3);
    // one byte more than the ring holds must raise the overrun flag
    serSend(17);
    rdChk(REG_STATUS, 32'h5);
    give_verdict();
  end
endmodule
`default_nettype wire
